// *** rtl/vref_temp_pkg.sv ***
/*
 * package for the voltage reference and temperature indicator control block:
 * register offset, bit positions, reset value and the packed analog control struct.
 * assumes a single 50 MHz core clock and a 32-bit Avalon-MM register port.
 */
package vref_temp_pkg;

    // register map (byte address)
    localparam logic [3:0]  CTRL_OFFSET     = 4'h0;   // control and status register
    localparam logic [3:0]  SENSE_OFFSET    = 4'h4;   // temperature channel status

    // bit positions of the control register
    localparam int          REF_EN_BIT      = 7;
    localparam int          REF_RDY_BIT     = 6;
    localparam int          TS_EN_BIT       = 5;
    localparam int          TS_RNG_BIT      = 4;
    localparam int          CMP_GAIN_LSB    = 2;
    localparam int          ADC_GAIN_LSB    = 0;

    // reset value of the writable bits
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    // ready flag on this family is hard wired high
    localparam logic        READY_CONST     = 1'b1;

    // settling time of reference and amplifiers, in ns, and as cycles at 20 ns
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          SETTLE_NS       = 100;
    localparam int          SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // temperature sample settle time, 200 us, as cycles at 20 ns
    localparam int          TEMP_WAIT_NS    = 200000;
    localparam int          TEMP_WAIT_CYC   = TEMP_WAIT_NS / CLK_PERIOD_NS;

    // dedicated adc channel that carries the temperature output
    localparam logic [4:0]  TEMP_ADC_CHAN   = 5'h1d;

    // buffer gain encodings
    typedef enum logic [1:0] {
        GAIN_OFF = 2'b00,
        GAIN_1X  = 2'b01,
        GAIN_2X  = 2'b10,
        GAIN_4X  = 2'b11
    } gain_t;

    // controls presented to the analog reference and sensor
    typedef struct packed {
        logic  reference_enable;
        logic  temp_sense_enable;
        logic  temp_range_select;
        gain_t comparator_ref_gain;
        gain_t adc_ref_gain;
    } analog_ctrl_t;

endpackage : vref_temp_pkg

// *** rtl/settle_timer.sv ***
/*
 * settle timer: counts enabled cycles after a start level rises and raises done.
 * assumes start is a level from a register in the same clock domain.
 */
module settle_timer #(
    parameter int CYCLES = 5                 // cycles counted after start; done rises one cycle after the last
) (
    input  wire logic sys_clk_i,             // core clock
    input  wire logic rst_i,                 // synchronous reset, active high
    input  wire logic ce_i,                  // clock enable
    input  wire logic start_i,               // level, restarts when low
    output logic      done_o                 // level, high once settled
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES);

    logic [W-1:0] cnt_ff;                    // elapsed cycles
    logic         done_ff;                   // settled flag
    wire          at_end = (cnt_ff == LAST); // terminal count reached

    // counter clears while start is low, saturates at the terminal count
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else if (ce_i) begin
            if (!start_i) begin
                cnt_ff  <= '0;
                done_ff <= 1'b0;
            end else if (!at_end) begin
                cnt_ff  <= cnt_ff + W'(1);
            end else begin
                done_ff <= 1'b1;
            end
        end
    end

    assign done_o = done_ff;

endmodule : settle_timer

// *** rtl/vref_temp_ctrl.sv ***
/*
 * control and status register of the fixed voltage reference and the on-die
 * temperature indicator, reached over an Avalon-MM slave with waitrequest.
 * assumes one core clock, synchronous active-high reset and a master that
 * holds its request until waitrequest is seen low.
 * every access costs one wait cycle: the read data come from a flop, which
 * keeps the read path short at the price of one extra cycle per access.
 * the ready flag is hard wired high here; the separate settle indication and
 * the status word still let software see when the buffers are usable.
 * the 200 us gap around temperature conversions is left to software, since
 * this block never sees the converter start a conversion.
 * a low clock enable freezes the register, the settle count and the bus answer.
 */
// Functional notes
// - bit 7 switches the voltage reference
// - bit 6 ready flag, reads one, read-only
// - bit 5 enables temperature indicator output
// - bit 4 picks high or low range
// - bits 3-2 comparator buffer gain, 00 off
// - bits 1-0 adc buffer gain, 00 off
// - all writable bits clear on reset
// - temperature output on its own adc channel
// - ready rises after reference has stabilised; here bit 6 always reads one, settling shows in status bit 0
module vref_temp_ctrl #(
    parameter int SETTLE_CYCLES = vref_temp_pkg::SETTLE_CYC   // reference settle cycles
) (
    input  wire logic                        sys_clk_i,          // core clock, 50 MHz
    input  wire logic                        rst_i,              // synchronous reset
    input  wire logic                        ce_i,               // clock enable, freezes all
    input  wire logic [3:0]                  avs_address_i,      // byte address
    input  wire logic                        avs_read_i,         // read request
    input  wire logic                        avs_write_i,        // write request
    input  wire logic [31:0]                 avs_writedata_i,    // write data
    input  wire logic [3:0]                  avs_byteenable_i,   // byte lanes
    output logic [31:0]                      avs_readdata_o,     // read data
    output logic                             avs_waitrequest_o,  // stall
    output logic [1:0]                       avs_response_o,     // 00 okay, 10 slave error
    output vref_temp_pkg::analog_ctrl_t      analog_ctrl_o,      // analog controls
    output logic                             ref_settled_o,      // reference stable
    output logic [4:0]                       temp_adc_chan_o     // channel of temp output
);

    // bus phase: one wait cycle, then the answer cycle.
    // the wait cycle lets the read data come from a flop, so the slave never
    // puts a combinational path from address to read data on the bus; a master
    // that pipelines requests gains nothing here, as only one is ever open
    // bus phase state
    logic                  ack_ff;               // answer cycle marker
    logic [31:0]           rdata_ff;             // registered read data
    logic [1:0]            resp_ff;              // registered response
    logic [7:0]            ctrl_ff;              // writable bits of the control register
    logic [7:0]            nxt_ctrl;             // next value of the control register
    logic                  settled;              // settle timer output

    wire req          = avs_read_i | avs_write_i;
    wire hit_ctrl     = (avs_address_i == vref_temp_pkg::CTRL_OFFSET);
    wire hit_sense    = (avs_address_i == vref_temp_pkg::SENSE_OFFSET);
    wire mapped       = hit_ctrl | hit_sense;
    // the write lands at the edge where waitrequest is low
    wire wr_ctrl      = avs_write_i & ack_ff & hit_ctrl & avs_byteenable_i[0];

    // bit 6 is not storage: writes are masked off and it reads as ready
    wire [7:0] wr_mask = 8'hff & ~(8'h01 << vref_temp_pkg::REF_RDY_BIT);
    assign nxt_ctrl = wr_ctrl ? (avs_writedata_i[7:0] & wr_mask) : ctrl_ff;

    // read view: stored bits plus the hard-wired ready flag
    wire [7:0] ctrl_view = ctrl_ff
                         | ({7'h00, vref_temp_pkg::READY_CONST} << vref_temp_pkg::REF_RDY_BIT);
    // status word: bit 0 reference stable, bits 12:8 temperature channel
    wire [31:0] sense_view = {19'h0, vref_temp_pkg::TEMP_ADC_CHAN, 7'h00, settled};
    wire [31:0] rd_mux = hit_ctrl  ? {24'h0, ctrl_view} :
                         hit_sense ? sense_view : 32'h0;

    // control register; reset clears every writable bit
    // reset wins over a low clock enable, so a frozen block still comes up clean
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_ff <= vref_temp_pkg::CTRL_RESET;
        end else if (ce_i) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // bus answer: ack toggles high for one cycle per held request
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
            resp_ff  <= 2'b00;
        end else if (ce_i) begin
            ack_ff   <= req & ~ack_ff;
            rdata_ff <= rd_mux;
            resp_ff  <= mapped ? 2'b00 : 2'b10;  // unmapped answers slave error
        end
    end

    // waitrequest is high during the first cycle of every request, and stays high
    // while the clock enable is low: an answer in a frozen cycle would let the
    // master walk away from a write that never reaches the register
    assign avs_waitrequest_o = req & ~(ack_ff & ce_i);
    assign avs_readdata_o    = rdata_ff;
    assign avs_response_o    = resp_ff;

    // stabilisation of reference and amplifiers after enable
    settle_timer #(
        .CYCLES   (SETTLE_CYCLES)
    ) u_settle (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .start_i   (ctrl_ff[vref_temp_pkg::REF_EN_BIT]),
        .done_o    (settled)
    );
    assign ref_settled_o = settled;

    // helper for the settle check: enabled cycles with the reference on,
    // saturating one past the settle count; it only feeds an assertion and is
    // written apart from the settle timer so that a fault there shows up
    localparam int       ON_W = $clog2(SETTLE_CYCLES + 2);  // width of the helper count
    logic [ON_W-1:0]     on_cnt_ff;                         // cycles with reference on
    wire                 on_full = (on_cnt_ff > ON_W'(SETTLE_CYCLES)); // settle time passed

    // helper count: restarts while the reference is off, frozen with the block
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            on_cnt_ff <= '0;
        end else if (ce_i) begin
            if (!analog_ctrl_o.reference_enable) begin
                on_cnt_ff <= '0;                                // restart when off
            end else if (!on_full) begin
                on_cnt_ff <= on_cnt_ff + ON_W'(1);              // count up to saturation
            end
        end
    end

    // gain fields picked out of the register flops
    wire [1:0] cmp_gain_bits = ctrl_ff[vref_temp_pkg::CMP_GAIN_LSB +: 2];
    wire [1:0] adc_gain_bits = ctrl_ff[vref_temp_pkg::ADC_GAIN_LSB +: 2];

    // analog controls straight from the register flops; one assignment keeps a
    // single driver on the packed output
    assign analog_ctrl_o = '{
        reference_enable    : ctrl_ff[vref_temp_pkg::REF_EN_BIT],
        temp_sense_enable   : ctrl_ff[vref_temp_pkg::TS_EN_BIT],
        temp_range_select   : ctrl_ff[vref_temp_pkg::TS_RNG_BIT],
        comparator_ref_gain : vref_temp_pkg::gain_t'(cmp_gain_bits),
        adc_ref_gain        : vref_temp_pkg::gain_t'(adc_gain_bits)
    };

    // fixed channel number; the 200 us sampling gap is software's job
    assign temp_adc_chan_o = vref_temp_pkg::TEMP_ADC_CHAN;

    // assertions
    // read data stand at the accepting edge, so the flag is checked there
    a_ready_reads_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (avs_read_i && hit_ctrl && !avs_waitrequest_o) |-> avs_readdata_o[6])
        else $error("ready flag read as zero");
    a_reset_clears: assert property (@(posedge sys_clk_i)
        rst_i |=> (ctrl_ff == 8'h00))
        else $error("control bits not cleared by reset");
    a_write_updates: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && ce_i) |=> (ctrl_ff == ($past(avs_writedata_i[7:0]) & 8'hbf)))
        else $error("control write not stored");
    a_ref_enable_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && ce_i) |=> (analog_ctrl_o.reference_enable == $past(avs_writedata_i[7])))
        else $error("reference enable mismatch");
    a_temp_en_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && ce_i) |=> (analog_ctrl_o.temp_sense_enable == $past(avs_writedata_i[5])))
        else $error("temperature enable mismatch");
    a_range_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && ce_i) |=> (analog_ctrl_o.temp_range_select == $past(avs_writedata_i[4])))
        else $error("range select mismatch");
    a_cmp_gain_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && ce_i) |=> (analog_ctrl_o.comparator_ref_gain == $past(avs_writedata_i[3:2])))
        else $error("comparator gain mismatch");
    a_adc_gain_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && ce_i) |=> (analog_ctrl_o.adc_ref_gain == $past(avs_writedata_i[1:0])))
        else $error("adc gain mismatch");
    a_settle_drop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!analog_ctrl_o.reference_enable && ce_i) |=> !ref_settled_o)
        else $error("settled while reference off");

    // the status word shows the dedicated channel wherever it is read
    a_status_channel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (avs_read_i && hit_sense && !avs_waitrequest_o)
        |-> (avs_readdata_o[12:8] == vref_temp_pkg::TEMP_ADC_CHAN))
        else $error("temperature channel missing from status");

    // the settle indication follows the helper count of enabled cycles with the reference on
    a_settle_time: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ref_settled_o == on_full)
        else $error("settle time differs from count");

    // exactly one wait cycle for a request seen with the clock enable high
    a_one_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (req && avs_waitrequest_o && ce_i) ##1 (req && ce_i) |-> !avs_waitrequest_o)
        else $error("more than one wait cycle");

    // unmapped places answer with slave error, mapped ones with okay
    a_resp_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (req && !avs_waitrequest_o) |-> (avs_response_o == (mapped ? 2'b00 : 2'b10)))
        else $error("wrong response code");

    // upper read lanes stay zero on the control register
    a_upper_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (avs_read_i && hit_ctrl && !avs_waitrequest_o) |-> (avs_readdata_o[31:8] == 24'h0))
        else $error("upper read lanes not zero");

    // a frozen cycle leaves the register untouched
    a_frozen_ctrl: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !ce_i |=> $stable(ctrl_ff))
        else $error("register changed while clock enable low");

    // without an accepted write the register keeps its value
    a_no_write_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!wr_ctrl && ce_i) |=> $stable(ctrl_ff))
        else $error("register changed without a write");

endmodule : vref_temp_ctrl

// *** tb/test_vref_temp_ctrl.sv ***
/*
 * self-checking bench for the reference and temperature control register.
 * assumes an Avalon-MM slave that answers after one wait cycle and a 50 MHz clock.
 */
module test_vref_temp_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SETTLE = 2;                  // shortened settle count keeps the run brief
    logic        sys_clk_i  = 1'b0;             // core clock
    logic        rst_i      = 1'b1;             // synchronous reset
    logic        ce_i       = 1'b1;             // clock enable, dropped low in the freeze test
    logic [3:0]  adr        = 4'h0;             // bus address
    logic        rd         = 1'b0;             // read request
    logic        wr         = 1'b0;             // write request
    logic [31:0] wdat       = 32'h0;            // write data
    logic [3:0]  be         = 4'hf;             // byte lanes
    logic [31:0] rdat;                          // read data
    logic        wreq;                          // waitrequest
    logic [1:0]  resp;                          // response code
    vref_temp_pkg::analog_ctrl_t actl;          // analog controls
    logic        settled;                       // reference stable
    logic [4:0]  chan;                          // temperature channel
    logic [31:0] got;                           // data of the last transfer
    logic [1:0]  gresp;                         // response of the last transfer
    logic [7:0]  v;                             // value written in loops
    int          err_total  = 0;                // mismatches
    int          n_compared = 0;                // comparisons
    int          cyc        = 0;                // cycles since start

    vref_temp_ctrl #(.SETTLE_CYCLES(SETTLE)) u_vref_temp_ctrl (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .avs_response_o(resp), .analog_ctrl_o(actl), .ref_settled_o(settled),
        .temp_adc_chan_o(chan));

    // free running clock, 20 ns period
    always #10 sys_clk_i = ~sys_clk_i;

    // print counts and verdict, then stop
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // a hang is cut short well past the expected run length
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            give_verdict();
        end
    end

    // one bus transfer: raise after an edge, hold until waitrequest is seen low
    // at a rising edge, take the answer at that same edge, then release
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge sys_clk_i);
        adr  <= a;
        wdat <= d;
        be   <= b;
        rd   <= ~w;
        wr   <= w;
        do @(posedge sys_clk_i); while (wreq !== 1'b0);
        got   = rdat;
        gresp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // settle n edges, then look mid-cycle
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : tick

    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : cmp

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(0);
        cmp(actl, 32'h0, "controls after reset");
        cmp(chan, 32'h1d, "temperature channel");
        bus(1'b0, 4'h0, 32'h0, 4'hf);
        cmp(got, 32'h40, "control after reset");
        $display("test reset done");
        // every gain code on both buffers, in opposite order
        for (int i = 0; i < 4; i++) begin
            v = 8'(i * 4 + (3 - i));
            bus(1'b1, 4'h0, {24'h0, v}, 4'h1);
            tick(0);
            cmp(actl.comparator_ref_gain, 32'(i), "comparator gain");
            cmp(actl.adc_ref_gain, 32'(3 - i), "adc gain");
            bus(1'b0, 4'h0, 32'h0, 4'hf);
            cmp(got, {24'h0, v | 8'h40}, "gain readback");
        end
        $display("test gains done");
        bus(1'b1, 4'h0, 32'hbf, 4'h1);
        tick(0);
        cmp(actl.reference_enable, 32'h1, "reference on");
        cmp(actl.temp_sense_enable, 32'h1, "sensor on");
        cmp(actl.temp_range_select, 32'h1, "high range");
        // no conversion is started here, so no 200 us sample gap is needed
        bus(1'b1, 4'h0, 32'h40, 4'h1);
        tick(0);
        cmp(actl, 32'h0, "all controls off, low range");
        bus(1'b0, 4'h0, 32'h0, 4'hf);
        cmp(got, 32'h40, "ready flag not writable");
        $display("test fields done");
        // settle timing of the reference-stable indication
        bus(1'b1, 4'h0, 32'h80, 4'h1);
        tick(SETTLE);
        cmp(settled, 32'h0, "not yet settled");
        tick(1);
        cmp(settled, 32'h1, "settled");
        bus(1'b0, 4'h4, 32'h0, 4'hf);
        cmp(got, 32'h1d01, "status word");
        bus(1'b1, 4'h0, 32'h0, 4'h1);
        tick(1);
        cmp(settled, 32'h0, "disabled drops settled");
        // a low clock enable freezes the settle count and the register
        bus(1'b1, 4'h0, 32'h80, 4'h1);
        ce_i <= 1'b0;
        tick(4);
        cmp(settled, 32'h0, "frozen while enable low");
        cmp(actl, 32'h40, "controls held while frozen");
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        tick(SETTLE + 1);
        cmp(settled, 32'h1, "settles once enable returns");
        bus(1'b1, 4'h0, 32'h0, 4'h1);
        $display("test settle done");
        // refused writes and an unmapped place
        bus(1'b1, 4'h4, 32'hff, 4'hf);
        bus(1'b1, 4'h0, 32'hff, 4'he);
        bus(1'b0, 4'h0, 32'h0, 4'hf);
        cmp(got, 32'h40, "refused writes ignored");
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        cmp(gresp, 32'h2, "unmapped response");
        cmp(got, 32'h0, "unmapped data");
        $display("test refusals done");
        // a second reset in mid-run clears what was written
        bus(1'b1, 4'h0, 32'hbf, 4'h1);
        tick(SETTLE + 2);
        cmp(settled, 32'h1, "settled before second reset");
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        tick(0);
        cmp(actl, 32'h0, "controls after second reset");
        cmp(settled, 32'h0, "settled after second reset");
        $display("test second reset done");
        give_verdict();
    end
endmodule : test_vref_temp_ctrl
